// >>> flow_map.svh
`ifndef FLOW_MAP_SVH
`define FLOW_MAP_SVH
// Register indices; byte address is four times the index
`define RTC_IDX      6'h01
`define PCL_IDX      6'h02
`define FLAGS_IDX    6'h03
`define FSR_IDX      6'h04
`define WREG_IDX     6'h05
// Flag field positions
`define CARRY_BIT    0
`define DC_BIT       1
`define ZERO_BIT     2
`define PD_BIT       3
`define TO_BIT       4
`define PAGE_LSB     5
`define PAGE_MSB     7
`define BANK_LSB     5
// Widths and reset values
`define PC_W         11
`define STACK_DEPTH  8
`define PC_RESET     11'h7FF
`define BYTE_RESET   8'h00
`define PAGE_RESET   3'h0
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// >>> flow_pkg.sv
package flow_pkg;
    // Operation class handed over by the decoder
    typedef enum logic [4:0] {
        OP_NONE   = 5'h00,
        OP_JUMP   = 5'h01,
        OP_CALL   = 5'h02,
        OP_PAGE   = 5'h03,
        OP_BANK   = 5'h04,
        OP_RET    = 5'h05,
        OP_PAGE_RESTORING_RETURN   = 5'h06,
        OP_INTERRUPT_RETURN   = 5'h07,
        OP_RETADD = 5'h08,
        OP_RETLIT = 5'h09,
        OP_DECSKP = 5'h0A,
        OP_INCSKP = 5'h0B,
        OP_SKPSET = 5'h0C,
        OP_SKPCLR = 5'h0D,
        OP_AND    = 5'h0E,
        OP_OR     = 5'h0F,
        OP_XOR    = 5'h10,
        OP_RL     = 5'h11,
        OP_RR     = 5'h12,
        OP_NOTF   = 5'h13,
        OP_NOTW   = 5'h14,
        OP_SWAPW  = 5'h15
    } op_t;
endpackage

// >>> flow_ctl.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "flow_map.svh"
//
// Behaviour
// - Jump loads PC bits 8:0 with the nine-bit target field.
// - Jump loads PC bits 10:9 from the page-select bits.
// - Page instruction writes page-select bits with page 0 to 3 in one cycle.
// - Call pushes current PC plus one onto the stack top.
// - Call copies the eight-bit address field into PC bits 7:0.
// - Call clears PC bit 8, targets lie in lower half page.
// - Call copies page-select bits into PC bits 10:9.
// - Return addresses live in an eight-level hardware stack.
// - Push shifts entries deeper, level one takes new, level eight lost.
// - Pop loads PC from level one, shifts up, level eight kept.
// - Plain, page-restoring and interrupt returns pop; only page-restoring sets page.
// - Return-add-counter pops and adds W into the real-time counter.
// - Return-with-literal pops and loads its literal into W.
// - Decrement or increment file register, skip next when result zero.
// - Skip instructions squash the next instruction when condition true.
// - Page or bank after a true skip is skipped too, three cycles.
// - Run of page or bank instructions all skipped plus next, cycle each.
// - AND, OR, XOR combine W with a data memory operand.
// - Rotate left and right of a file register through carry.
// - One's complement of file register or W.
// - Swapped move puts nibble-swapped file register into W, source kept.
// - Flags: carry 0, digit carry 1, zero 2, power-down 3, timeout 4, page 7:5.
// - Each stack entry is eleven bits wide.
//
module flow_ctl #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    // Instruction from decoder
    input  wire logic                ins_valid,
    input  wire flow_pkg::op_t       ins_op,
    input  wire logic [8:0]          ins_arg,
    input  wire logic [2:0]          ins_bit,
    input  wire logic                ins_to_fr,
    input  wire logic [7:0]          fr_rdata,
    // Status inputs from power logic
    input  wire logic                power_down_flag,
    input  wire logic                timeout_flag,
    // Results
    output logic [`PC_W-1:0]         pc,
    output logic [7:0]               w_out,
    output logic                     fr_we,
    output logic [7:0]               fr_wdata,
    output logic                     skip_active,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    import flow_pkg::*;

    localparam int DEPTH = `STACK_DEPTH;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [`PC_W-1:0] pc_reg;
    logic [`PC_W-1:0] stk [1:DEPTH];
    logic [7:0]       w_reg;
    logic [7:0]       rtc_reg;
    logic [7:0]       fsr_reg;
    logic [2:0]       page_reg;
    logic             c_reg;
    logic             dc_reg;
    logic             z_reg;
    logic             skip_reg;
    logic             fr_we_reg;
    logic [7:0]       fr_wdata_reg;

    // ------------------------------------------------------------
    // Bus write decode
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr_reg;
    logic              aw_held;
    logic [7:0]        wd_reg;
    logic              wd_en;
    logic              w_held;
    logic              bus_wr;
    logic [5:0]        wr_idx;
    logic [5:0]        rd_idx;

    assign bus_wr = ce && aw_held && w_held && !s_axi_bvalid;
    // Misaligned addresses map to an unused index, so they answer an error and change nothing
    assign wr_idx = (aw_addr_reg[1:0] == 2'h0) ? aw_addr_reg[7:2] : 6'h3F;
    assign rd_idx = (s_axi_araddr[1:0] == 2'h0) ? s_axi_araddr[7:2] : 6'h3F;

    // ------------------------------------------------------------
    // Execute decode
    // ------------------------------------------------------------
    logic       exec;
    logic       squash;
    logic       is_ret;
    logic       is_pop;
    logic [7:0] fr_res;
    logic       fr_upd;
    logic       skip_cond;
    logic       c_res;

    assign exec   = ce && ins_valid && !skip_reg;
    assign squash = ce && ins_valid && skip_reg;
    assign is_ret = ins_op inside {OP_RET, OP_PAGE_RESTORING_RETURN, OP_INTERRUPT_RETURN, OP_RETADD, OP_RETLIT};
    assign is_pop = exec && is_ret;

    // Datapath result for file-register style operations
    always_comb
    begin
        fr_res    = fr_rdata;
        fr_upd    = 1'b0;
        skip_cond = 1'b0;
        c_res     = c_reg;
        case (ins_op)
            OP_DECSKP:
            begin
                fr_res    = fr_rdata - 8'h01;
                fr_upd    = 1'b1;
                skip_cond = (fr_res == 8'h00);
            end
            OP_INCSKP:
            begin
                fr_res    = fr_rdata + 8'h01;
                fr_upd    = 1'b1;
                skip_cond = (fr_res == 8'h00);
            end
            OP_SKPSET: skip_cond = fr_rdata[ins_bit];
            OP_SKPCLR: skip_cond = !fr_rdata[ins_bit];
            OP_AND:    fr_res = fr_rdata & w_reg;
            OP_OR:     fr_res = fr_rdata | w_reg;
            OP_XOR:    fr_res = fr_rdata ^ w_reg;
            OP_RL:
            begin
                fr_res = {fr_rdata[6:0], c_reg};
                c_res  = fr_rdata[7];
                fr_upd = 1'b1;
            end
            OP_RR:
            begin
                fr_res = {c_reg, fr_rdata[7:1]};
                c_res  = fr_rdata[0];
                fr_upd = 1'b1;
            end
            OP_NOTF:
            begin
                fr_res = ~fr_rdata;
                fr_upd = 1'b1;
            end
            OP_SWAPW:  fr_res = {fr_rdata[3:0], fr_rdata[7:4]};
            default:   fr_res = fr_rdata;
        endcase
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    // A bus write to the low byte lands after the instruction, as a computed jump
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pc_reg <= `PC_RESET;
        else if (ce)
        begin
            if (exec && ins_op == OP_JUMP)
                pc_reg <= {page_reg[1:0], ins_arg};
            else if (exec && ins_op == OP_CALL)
                pc_reg <= {page_reg[1:0], 1'b0, ins_arg[7:0]};
            else if (is_pop)
                pc_reg <= stk[1];
            else if (ins_valid)
                pc_reg <= pc_reg + 11'h001;
            if (bus_wr && wr_idx == `PCL_IDX)
                pc_reg <= {page_reg[1:0], 1'b0, wd_reg};
        end
    end

    // ------------------------------------------------------------
    // Return stack, one process per level
    // ------------------------------------------------------------
    for (genvar i = 1; i <= DEPTH; i++)
    begin : g_stk
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                stk[i] <= `PC_W'(0);
            else if (ce && exec && ins_op == OP_CALL)
            begin
                if (i == 1)
                    stk[i] <= pc_reg + 11'h001;
                else
                    stk[i] <= stk[(i > 1) ? i - 1 : 1];
            end
            else if (ce && is_pop && i < DEPTH)
                stk[i] <= stk[(i < DEPTH) ? i + 1 : DEPTH];
        end
    end

    // ------------------------------------------------------------
    // Skip tracking
    // ------------------------------------------------------------
    // Page and bank squashed under a skip keep it armed, one cycle each
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            skip_reg <= 1'b0;
        else if (ce)
        begin
            if (squash)
                skip_reg <= (ins_op == OP_PAGE || ins_op == OP_BANK);
            else if (exec)
                skip_reg <= skip_cond;
        end
    end

    // ------------------------------------------------------------
    // Working register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            w_reg <= `BYTE_RESET;
        else if (ce)
        begin
            if (exec && ins_op == OP_RETLIT)
                w_reg <= ins_arg[7:0];
            else if (exec && ins_op == OP_NOTW)
                w_reg <= ~w_reg;
            else if (exec && ins_op == OP_SWAPW)
                w_reg <= fr_res;
            else if (exec && ins_op inside {OP_AND, OP_OR, OP_XOR} && !ins_to_fr)
                w_reg <= fr_res;
            if (bus_wr && wr_idx == `WREG_IDX)
                w_reg <= wd_reg;
        end
    end

    // ------------------------------------------------------------
    // File register write-back
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fr_we_reg    <= 1'b0;
            fr_wdata_reg <= `BYTE_RESET;
        end
        else if (ce)
        begin
            fr_we_reg    <= exec && (fr_upd ||
                            (ins_op inside {OP_AND, OP_OR, OP_XOR} && ins_to_fr));
            fr_wdata_reg <= fr_res;
        end
    end

    // ------------------------------------------------------------
    // Counter, pointer and flags
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rtc_reg <= `BYTE_RESET;
        else if (ce)
        begin
            if (exec && ins_op == OP_RETADD)
                rtc_reg <= rtc_reg + w_reg;
            if (bus_wr && wr_idx == `RTC_IDX)
                rtc_reg <= wd_reg;
        end
    end

    // Bank selects the top three pointer bits only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fsr_reg <= `BYTE_RESET;
        else if (ce)
        begin
            if (exec && ins_op == OP_BANK)
                fsr_reg[7:`BANK_LSB] <= ins_arg[7:`BANK_LSB];
            if (bus_wr && wr_idx == `FSR_IDX)
                fsr_reg <= wd_reg;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            page_reg <= `PAGE_RESET;
        else if (ce)
        begin
            if (exec && ins_op == OP_PAGE)
                page_reg <= {1'b0, ins_arg[1:0]};
            else if (exec && ins_op == OP_PAGE_RESTORING_RETURN)
                page_reg <= {1'b0, stk[1][10:9]};
            if (bus_wr && wr_idx == `FLAGS_IDX)
                page_reg <= wd_reg[`PAGE_MSB:`PAGE_LSB];
        end
    end

    // Zero follows logic results; carry follows rotates
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            c_reg  <= 1'b0;
            dc_reg <= 1'b0;
            z_reg  <= 1'b0;
        end
        else if (ce)
        begin
            if (exec && ins_op inside {OP_AND, OP_OR, OP_XOR, OP_NOTF})
                z_reg <= (fr_res == 8'h00);
            else if (exec && ins_op == OP_NOTW)
                z_reg <= (w_reg == 8'hFF);
            if (exec && ins_op inside {OP_RL, OP_RR})
                c_reg <= c_res;
            if (bus_wr && wr_idx == `FLAGS_IDX)
            begin
                c_reg  <= wd_reg[`CARRY_BIT];
                dc_reg <= wd_reg[`DC_BIT];
                z_reg  <= wd_reg[`ZERO_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data are taken in either order, then answered together
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr_reg  <= '0;
            wd_reg       <= `BYTE_RESET;
            wd_en        <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held     <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                wd_reg <= s_axi_wdata[7:0];
                wd_en  <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (bus_wr)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_idx >= `RTC_IDX && wr_idx <= `WREG_IDX &&
                                 aw_addr_reg[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                // Both channels reopen only once the response has retired
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end


    // Reserved bits read as zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rresp  <= `RESP_OKAY;
                case (rd_idx)
                    `RTC_IDX:   s_axi_rdata <= {24'h0, rtc_reg};
                    `PCL_IDX:   s_axi_rdata <= {24'h0, pc_reg[7:0]};
                    `FLAGS_IDX: s_axi_rdata <= {24'h0, page_reg, timeout_flag,
                                                power_down_flag, z_reg, dc_reg, c_reg};
                    `FSR_IDX:   s_axi_rdata <= {24'h0, fsr_reg};
                    `WREG_IDX:  s_axi_rdata <= {24'h0, w_reg};
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end


    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pc          = pc_reg;
    assign w_out       = w_reg;
    assign fr_we       = fr_we_reg;
    assign fr_wdata    = fr_wdata_reg;
    assign skip_active = skip_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic pcl_wr;
    assign pcl_wr = bus_wr && wr_idx == `PCL_IDX;

    sequence s_true_skip;
        exec && ins_op inside {OP_DECSKP, OP_INCSKP, OP_SKPSET, OP_SKPCLR} && skip_cond;
    endsequence
    sequence s_page_squash;
        squash && ins_op inside {OP_PAGE, OP_BANK};
    endsequence

    property p_jump;
        exec && ins_op == OP_JUMP && !pcl_wr |=>
            pc_reg == {$past(page_reg[1:0]), $past(ins_arg)};
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    property p_call;
        exec && ins_op == OP_CALL && !pcl_wr |=>
            pc_reg == {$past(page_reg[1:0]), 1'b0, $past(ins_arg[7:0])}
            && stk[1] == $past(pc_reg) + 11'h001;
    endproperty
    a_call: assert property (p_call) else $error("call target or push wrong");

    property p_push_deep;
        exec && ins_op == OP_CALL |=> stk[DEPTH] == $past(stk[DEPTH-1]);
    endproperty
    a_push_deep: assert property (p_push_deep) else $error("push shift wrong");

    property p_pop;
        is_pop && !pcl_wr |=> pc_reg == $past(stk[1])
            && stk[DEPTH-1] == $past(stk[DEPTH]) && stk[DEPTH] == $past(stk[DEPTH]);
    endproperty
    a_pop: assert property (p_pop) else $error("pop wrong");

    property p_retlit;
        exec && ins_op == OP_RETLIT && !bus_wr |=> w_reg == $past(ins_arg[7:0]);
    endproperty
    a_retlit: assert property (p_retlit) else $error("literal return W wrong");

    property p_retadd;
        exec && ins_op == OP_RETADD && !bus_wr |=> rtc_reg == $past(rtc_reg) + $past(w_reg);
    endproperty
    a_retadd: assert property (p_retadd) else $error("counter add wrong");

    property p_page_chain;
        s_true_skip ##[1:2] s_page_squash |=> skip_reg;
    endproperty
    a_page_chain: assert property (p_page_chain) else $error("page skip lost");

    property p_squash;
        squash |=> !fr_we_reg;
    endproperty
    a_squash: assert property (p_squash) else $error("skipped op wrote");

    property p_advance;
        exec && ins_op inside {OP_AND, OP_NOTW, OP_PAGE} && !pcl_wr |=>
            pc_reg == $past(pc_reg) + 11'h001;
    endproperty
    a_advance: assert property (p_advance) else $error("pc not advanced");
endmodule

// >>> insn_feed.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Decoder and fetch stand-in
// -----------------------------------------------------------------
module insn_feed (
    // Clock
    input  wire logic     aclk,
    // Instruction to the core
    output logic          ins_valid,
    output flow_pkg::op_t ins_op,
    output logic [8:0]    ins_arg,
    output logic [2:0]    ins_bit,
    output logic          ins_to_fr,
    output logic [7:0]    fr_rdata
);
    import flow_pkg::*;
    // Idle values at time zero
    initial
    begin
        {ins_valid, ins_arg, ins_bit, fr_rdata} = '0;
        ins_op = OP_NONE;
        ins_to_fr = 1'b1;
    end
    // Offer for one edge; the operand bus inverts once withdrawn so stale data never matches
    task automatic issue(input op_t o, input logic [8:0] a = 9'h000,
                         input logic [7:0] d = 8'h00, input logic [2:0] b = 3'h0,
                         input logic t = 1'b1);
        @(posedge aclk);
        ins_valid <= 1'b1;
        ins_op    <= o;
        ins_arg   <= a;
        ins_bit   <= b;
        ins_to_fr <= t;
        fr_rdata  <= d;
        @(posedge aclk);
        ins_valid <= 1'b0;
        fr_rdata  <= ~d;
        @(negedge aclk);
    endtask
endmodule

// >>> program_flow_and_call_stack_tb.sv
`timescale 1ns/1ps
module program_flow_and_call_stack_tb;
    import flow_pkg::*;
    // -------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------
    logic        aclk, aresetn, pd, tmo, ins_valid, fr_we, skp, tofr;
    logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
    op_t         ins_op;
    logic [8:0]  ins_arg;
    logic [2:0]  ins_bit;
    logic [7:0]  fr_rdata, w_out, fr_wdata, awa, ara, x, lit;
    logic [10:0] pc;
    logic [31:0] wd, rdat, q;
    logic [1:0]  bresp, rresp, rs;
    logic [7:0]  exp_q[$];
    int          fail_count, tests_run, i;
    // Design and fetch stand-in
    flow_ctl uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .ins_valid(ins_valid),
        .ins_op(ins_op), .ins_arg(ins_arg), .ins_bit(ins_bit), .ins_to_fr(tofr),
        .fr_rdata(fr_rdata), .power_down_flag(pd), .timeout_flag(tmo), .pc(pc),
        .w_out(w_out), .fr_we(fr_we), .fr_wdata(fr_wdata), .skip_active(skp),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr));
    insn_feed fd (.aclk(aclk), .ins_valid(ins_valid), .ins_op(ins_op), .ins_arg(ins_arg),
        .ins_bit(ins_bit), .ins_to_fr(tofr), .fr_rdata(fr_rdata));
    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Each channel is released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awa, wd, awv, wv, br} <= {a, d, 3'b111};
        do
        begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end
        while (bv !== 1'b1);
        br <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        {ara, arv, rr} <= {a, 2'b11};
        do
        begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end
        while (rv !== 1'b1);
        {q, rs} = {rdat, rresp};
        rr <= 1'b0;
    endtask
    // -------------------------------------------------------------
    // Clock, write-back monitor, hang limit
    // -------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Every write-back pulse retires the oldest expected byte
    always @(posedge aclk)
        if (fr_we === 1'b1)
            chk(fr_wdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    // Far above the two hundred or so cycles the sequence needs
    initial
    begin
        repeat (8000) @(posedge aclk);
        fail_count++;
        end_sim();
    end
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial
    begin
        {aresetn, awv, wv, br, arv, rr, awa, ara, wd} = '0;
        x = 8'($urandom(55232));
        {pd, tmo} = x[1:0];
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h0C);
        chk(q, {27'h0, tmo, pd, 3'h0});
        rd(8'h40);
        chk(rs, 2'h2);
        // Jump takes its top bits from the page field
        fd.issue(OP_PAGE, 9'h002);
        fd.issue(OP_JUMP, 9'h1AB);
        chk(pc, 11'h5AB);
        chk(pc[10:9], 2'h2);
        rd(8'h0C);
        chk(q[7:5], 3'h2);
        // Nine nested calls: the first return address falls off the bottom
        fd.issue(OP_PAGE, 9'h001);
        for (i = 1; i <= 9; i++)
        begin
            fd.issue(OP_CALL, 9'(8 * i));
            chk(pc, 11'(12'h200 + 8 * i));
        end
        for (i = 8; i >= 0; i--)
        begin
            fd.issue(OP_RET);
            chk(pc, 11'(12'h201 + 8 * (i > 0 ? i : 1)));
        end
        fd.issue(OP_CALL, 9'h1FF);
        chk(pc, 11'h2FF);
        fd.issue(OP_PAGE, 9'h003);
        fd.issue(OP_PAGE_RESTORING_RETURN);
        chk(pc, 11'h20A);
        rd(8'h0C);
        chk(q[6:5], 2'h1);
        // Return variants and their side effects on W and the counter
        {lit, x} = 16'($urandom);
        wr(8'h14, {24'h0, lit});
        wr(8'h04, {24'h0, x});
        fd.issue(OP_RETADD);
        rd(8'h04);
        chk(q, {24'h0, x + lit});
        lit = ~lit;
        fd.issue(OP_RETLIT, {1'b0, lit});
        chk(w_out, lit);
        fd.issue(OP_INTERRUPT_RETURN);
        chk(w_out, lit);
        chk(pc, 11'h209);
        // Operand ops; flags cleared so carry starts at zero
        wr(8'h0C, 32'h0);
        x = 8'($urandom);
        fd.issue(OP_AND, 9'h0, x);
        exp_q.push_back(x & lit);
        fd.issue(OP_OR, 9'h0, x);
        exp_q.push_back(x | lit);
        fd.issue(OP_XOR, 9'h0, x);
        exp_q.push_back(x ^ lit);
        fd.issue(OP_RL, 9'h0, x);
        exp_q.push_back({x[6:0], 1'b0});
        fd.issue(OP_RR, 9'h0, lit);
        exp_q.push_back({x[7], lit[7:1]});
        fd.issue(OP_NOTF, 9'h0, x);
        exp_q.push_back(~x);
        fd.issue(OP_NOTW);
        lit = ~lit;
        chk(w_out, lit);
        fd.issue(OP_SWAPW, 9'h0, x);
        chk(w_out, {x[3:0], x[7:4]});
        // Logic result steered to W instead of the file register
        lit = 8'($urandom);
        fd.issue(OP_AND, 9'h0, lit, 3'h0, 1'b0);
        chk(w_out, lit & {x[3:0], x[7:4]});
        // True skip followed by a run of page and bank selects
        fd.issue(OP_JUMP, 9'h100);
        fd.issue(OP_DECSKP, 9'h0, 8'h01);
        exp_q.push_back(8'h00);
        chk(skp, 1'b1);
        fd.issue(OP_PAGE, 9'h003);
        fd.issue(OP_BANK, 9'h0F0);
        chk(skp, 1'b1);
        fd.issue(OP_JUMP, 9'h000);
        chk(pc, 11'h104);
        rd(8'h0C);
        chk(q[7:5], 3'h0);
        fd.issue(OP_INCSKP, 9'h0, 8'h05);
        exp_q.push_back(8'h06);
        chk(skp, 1'b0);
        // Bit tests over every bit position, both senses
        for (i = 0; i < 16; i++)
        begin
            x = 8'($urandom);
            fd.issue(i < 8 ? OP_SKPSET : OP_SKPCLR, 9'h0, x, 3'(i));
            chk(skp, x[i % 8] ^ (i >= 8));
            fd.issue(OP_NONE);
        end
        wr(8'h08, 32'hC3);
        chk(pc, 11'h0C3);
        repeat (2) @(posedge aclk);
        chk(exp_q.size(), 0);
        end_sim();
    end
endmodule
